// File: glue_pkg.sv
// shared constants for the bank latch glue block
package glue_pkg;

  // data and select widths
  localparam int DATA_W     = 8;
  localparam int BANK_W     = 3;
  localparam int SLOT_MEM_W = 3;
  localparam int SLOT_IO_W  = 3;
  localparam int FORCED_W   = 3;

  // i/o port addresses on the main cpu low address byte
  localparam logic [7:0] PORT_RETURN_DATA = 8'h33;
  localparam logic [7:0] PORT_BANK_SELECT = 8'h3d;

  // bank latch value while system reset is low: high, low, high
  localparam logic [2:0] BANK_RESET = 3'h5;

  // bit of the bank latch that splits the bank 3 window
  localparam int BANK_SPLIT_BIT = 2;

  // bank 3 memory window bounds
  localparam logic [15:0] BANK3_BASE = 16'h4000;
  localparam logic [15:0] BANK3_LAST = 16'h7fff;

  // data bus lanes forced low during system-off
  localparam logic [7:0] FORCED_LANES = 8'h07;

  // value driven on forced lanes
  localparam logic [2:0] FORCED_VALUE = 3'h0;

  // data register value after reset
  localparam logic [7:0] DATA_RESET = 8'h00;

  // registered address and key outputs after reset
  localparam logic INV_ADDR_RESET = 1'b0;
  localparam logic KEY_HIGH_RESET = 1'b0;

endpackage

// File: select_gate.sv
// gates a group of active-low selects high while power is unsafe
`timescale 1ns/100ps
`default_nettype none

module select_gate #(
  parameter int WIDTH = 3
) (
  input  wire logic [WIDTH-1:0] sel_n_in,   // incoming active-low selects
  input  wire logic             block_in,   // high forces all selects inactive
  output logic      [WIDTH-1:0] sel_n_out   // gated active-low selects
);

  always_comb begin
    if (block_in) begin
      sel_n_out = '1;
    end else begin
      sel_n_out = sel_n_in;
    end
  end

endmodule

`default_nettype wire

// File: system_glue_bank_latch.sv
// glue between the main cpu bus, the secondary cpu, memory slots and the uart clock
//
// Notes on behaviour
// - combined read strobe low only while the secondary cpu reads memory or i/o
// - system-off flag high forces data lanes 0 to 2 low
// - command/data strobe high on main cpu i/o write to port 3dh
// - the strobe latches data bits 2..0 onto the bank address outputs
// - i/o read of port 33h enables return data onto the main data bus
// - system reset low forces bank address outputs to high, low, high
// - inverted address bit 13 output is the inverse of address bit 13
// - active-low break key is sent inverted as active-high key signal
// - sub clock passes to the uart clock while on, low while off
// - top bank address bit splits the bank 3 window into two banks
// - on and battery good: slot selects pass straight through
// - off or weak battery: all six slot selects driven high
// - combined read output floats while the main cpu operates
`timescale 1ns/100ps
`default_nettype none

module system_glue_bank_latch
  import glue_pkg::*;
#(
  parameter int RET_W = DATA_W
) (
  input  wire logic                  sys_clk_in,                // 40 mhz system clock
  input  wire logic                  nrst_in,                   // async reset, active low

  // main cpu i/o bus
  input  wire logic [7:0]            addr_low_in,               // address bits 7..0
  input  wire logic                  addr_bit13_in,             // address bit 13
  input  wire logic                  iorq_n_in,                 // i/o request, low active
  input  wire logic                  rd_n_in,                   // read, low active
  input  wire logic                  wr_n_in,                   // write, low active
  input  wire logic [DATA_W-1:0]     data_in,                   // data bus level
  output logic      [DATA_W-1:0]     data_out,                  // data bus drive value
  output logic      [DATA_W-1:0]     data_oe_n_out,             // data lane enables, low drives
  input  wire logic                  main_cpu_active_in,        // main cpu owns the bus

  // secondary cpu read strobe sources
  input  wire logic                  memory_enable_zero_in,     // memory enable 0
  input  wire logic                  memory_enable_one_in,      // memory enable 1
  input  wire logic                  sub_read_timing_in,        // read timing, low active
  input  wire logic                  clock_phase_in,            // secondary clock phase
  input  wire logic                  bus_request_in,            // bus request
  output logic                       combined_read_n_out,       // combined read, low active
  output logic                       combined_read_oe_n_out,    // read pin enable, low drives

  // secondary cpu status and return data
  input  wire logic                  system_off_flag_in,        // high while system is off
  input  wire logic                  weak_battery_in,           // high on weak battery
  input  wire logic                  system_reset_n_in,         // system reset, low active
  input  wire logic [RET_W-1:0]      secondary_return_bits_in,  // return data bits
  output logic                       return_data_enable_n_out,  // return enable, low active
  output logic                       cmd_data_strobe_out,       // command/data strobe

  // address translation and bank select
  output logic [BANK_W-1:0]          bank_address_outputs_out,  // latched bank address
  output logic                       inverted_addr_bit13_out,   // inverted address bit 13
  input  wire logic                  bank3_chip_select_n_in,    // bank 3 window select
  output logic                       bank3_lower_sel_n_out,     // lower bank 3 half select
  output logic                       bank3_upper_sel_n_out,     // upper bank 3 half select

  // key and clock
  input  wire logic                  break_key_n_in,            // break/on key, low pressed
  output logic                       key_break_high_out,        // key pressed, high active
  input  wire logic                  sub_clock_in,              // 1.229 mhz sub clock
  output logic                       uart_clock_out,            // uart base clock

  // slot selects
  input  wire logic [SLOT_MEM_W-1:0] slot_memory_select_n_in,   // memory selects in
  input  wire logic [SLOT_IO_W-1:0]  slot_io_select_n_in,       // i/o selects in
  output logic      [SLOT_MEM_W-1:0] slot_memory_select_n_out,  // memory selects out
  output logic      [SLOT_IO_W-1:0]  slot_io_select_n_out       // i/o selects out
);

  logic io_read;
  logic io_write;
  logic ret_read;
  logic bank_write;
  logic bank_write_d;
  logic bank_write_rise;
  logic slot_block;
  logic sub_reading;
  logic addr_is_return;
  logic addr_is_bank;
  logic sub_mem_cycle;
  logic sub_read_phase;
  logic sub_bus_free;

  // main cpu i/o cycle decode
  assign io_read  = !iorq_n_in && !rd_n_in;
  assign io_write = !iorq_n_in && !wr_n_in;

  // full eight-bit port compare, so neighbouring ports stay untouched
  assign addr_is_return = (addr_low_in == PORT_RETURN_DATA);
  assign addr_is_bank   = (addr_low_in == PORT_BANK_SELECT);

  assign ret_read   = io_read && addr_is_return;
  assign bank_write = io_write && addr_is_bank;

  // strobe follows the write decode with no clock delay
  assign cmd_data_strobe_out = bank_write;

  // enable follows the read decode with no clock delay
  assign return_data_enable_n_out = !ret_read;

  // latch once per write cycle, on the strobe's leading edge
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_write_d <= 1'b0;
    end else begin
      bank_write_d <= bank_write;
    end
  end

  assign bank_write_rise = bank_write && !bank_write_d;

  // bank latch; system reset takes priority over a write
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_address_outputs_out <= BANK_RESET;
    end else if (!system_reset_n_in) begin
      bank_address_outputs_out <= BANK_RESET;
    end else if (bank_write_rise) begin
      bank_address_outputs_out <= data_in[BANK_W-1:0];
    end else begin
      bank_address_outputs_out <= bank_address_outputs_out;
    end
  end

  // bank 3 window split by the top latch bit
  always_comb begin
    bank3_lower_sel_n_out = 1'b1;
    bank3_upper_sel_n_out = 1'b1;
    if (!bank3_chip_select_n_in) begin
      if (bank_address_outputs_out[BANK_SPLIT_BIT]) begin
        bank3_upper_sel_n_out = 1'b0;
      end else begin
        bank3_lower_sel_n_out = 1'b0;
      end
    end
  end

  // data bus drive value, sampled every cycle
  // low lanes held at zero while off so their input level is fixed
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_out <= DATA_RESET;
    end else if (system_off_flag_in) begin
      data_out <= {secondary_return_bits_in[DATA_W-1:FORCED_W], FORCED_VALUE};
    end else begin
      data_out <= secondary_return_bits_in[DATA_W-1:0];
    end
  end

  // lane enables: return read drives all, system-off drives the low lanes
  always_comb begin
    if (ret_read) begin
      data_oe_n_out = '0;
    end else if (system_off_flag_in) begin
      data_oe_n_out = ~FORCED_LANES;
    end else begin
      data_oe_n_out = '1;
    end
  end

  // secondary cpu read detection
  assign sub_mem_cycle  = memory_enable_zero_in || memory_enable_one_in;
  assign sub_read_phase = !sub_read_timing_in && clock_phase_in;
  assign sub_bus_free   = !bus_request_in;

  // read timing alone also idles low, so qualify it with the cycle type
  assign sub_reading = sub_mem_cycle && sub_read_phase && sub_bus_free;

  assign combined_read_n_out    = !sub_reading;
  // wire-ored with the main cpu read, so float while it owns the bus
  assign combined_read_oe_n_out = main_cpu_active_in;

  // registered inverted address bit 13
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      inverted_addr_bit13_out <= INV_ADDR_RESET;
    end else begin
      inverted_addr_bit13_out <= !addr_bit13_in;
    end
  end

  // registered active-high key
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      key_break_high_out <= KEY_HIGH_RESET;
    end else begin
      key_break_high_out <= !break_key_n_in;
    end
  end

  // gated so the uart clock edges follow the sub clock directly
  assign uart_clock_out = sub_clock_in && !system_off_flag_in;

  // slot devices lose power when off, so their selects must stay inactive
  assign slot_block = system_off_flag_in || weak_battery_in;

  select_gate #(
    .WIDTH (SLOT_MEM_W)
  ) u_mem_gate (
    .sel_n_in  (slot_memory_select_n_in),
    .block_in  (slot_block),
    .sel_n_out (slot_memory_select_n_out)
  );

  select_gate #(
    .WIDTH (SLOT_IO_W)
  ) u_io_gate (
    .sel_n_in  (slot_io_select_n_in),
    .block_in  (slot_block),
    .sel_n_out (slot_io_select_n_out)
  );

endmodule

`default_nettype wire

// File: system_glue_bank_latch_properties.sv
// concurrent checks on the bank latch glue block ports
`timescale 1ns/100ps
`default_nettype none
module system_glue_bank_latch_properties (
  input wire logic       sys_clk_in,               // system clock
  input wire logic       nrst_in,                  // async reset, active low
  input wire logic [7:0] addr_low_in,              // low address byte
  input wire logic       iorq_n_in,                // i/o request
  input wire logic       rd_n_in,                  // read strobe
  input wire logic       wr_n_in,                  // write strobe
  input wire logic [7:0] data_in,                  // data bus level
  input wire logic       system_reset_n_in,        // system reset
  input wire logic [2:0] bank_address_outputs_out, // bank latch
  input wire logic       cmd_data_strobe_out,      // write strobe out
  input wire logic       return_data_enable_n_out, // return enable
  input wire logic       addr_bit13_in,            // address bit 13
  input wire logic       inverted_addr_bit13_out,  // inverted bit 13
  input wire logic       break_key_n_in,           // break key
  input wire logic       key_break_high_out,       // key out
  input wire logic       system_off_flag_in,       // system off
  input wire logic       weak_battery_in,          // weak battery
  input wire logic       sub_clock_in,             // sub clock
  input wire logic       uart_clock_out,           // uart clock
  input wire logic [2:0] slot_io_select_n_out      // i/o selects out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_STROBE: assert property (
    cmd_data_strobe_out == (!iorq_n_in && !wr_n_in && addr_low_in == 8'h3d)) else $error("strobe");
  AST_RET_EN: assert property (
    !return_data_enable_n_out == (!iorq_n_in && !rd_n_in && addr_low_in == 8'h33)) else $error("ret");
  AST_LATCH: assert property ($rose(cmd_data_strobe_out) && system_reset_n_in
    |=> bank_address_outputs_out == $past(data_in[2:0])) else $error("latch");
  AST_SYS_RESET: assert property (!system_reset_n_in
    |=> bank_address_outputs_out == 3'h5) else $error("sys reset");
  AST_HOLD: assert property (!$rose(cmd_data_strobe_out) && system_reset_n_in
    |=> $stable(bank_address_outputs_out)) else $error("hold");
  AST_ADDR13: assert property (1'b1
    |=> inverted_addr_bit13_out != $past(addr_bit13_in)) else $error("a13");
  AST_KEY: assert property (1'b1
    |=> key_break_high_out == !$past(break_key_n_in)) else $error("key");
  AST_UART: assert property (
    uart_clock_out == (sub_clock_in && !system_off_flag_in)) else $error("uart");
  AST_SLOT_OFF: assert property ((system_off_flag_in || weak_battery_in)
    |-> slot_io_select_n_out == 3'h7) else $error("slot");
  cover property ($rose(cmd_data_strobe_out));
  cover property (!return_data_enable_n_out);
  cover property (!system_reset_n_in ##1 system_reset_n_in);
endmodule
`default_nettype wire

// File: main_bus_model.sv
// main cpu i/o bus model for the glue block
`timescale 1ns/100ps
`default_nettype none
module main_bus_model (
  input  wire logic       clk_in,     // bus clock
  input  wire logic [7:0] bus_in,     // resolved data wire
  output logic      [7:0] addr_out,   // low address byte
  output logic            iorq_n_out, // i/o request
  output logic            rd_n_out,   // read strobe
  output logic            wr_n_out,   // write strobe
  output logic      [7:0] drv_out     // data drive value
);
  initial begin
    {addr_out, drv_out} = 16'h0;
    {iorq_n_out, rd_n_out, wr_n_out} = 3'h7;
  end
  // one i/o cycle; released bus shows inverted data
  task automatic cycle(input logic [7:0] a, input logic [7:0] d, input logic wr,
                       output logic [7:0] q);
    @(posedge clk_in);
    #1;
    addr_out = a;
    drv_out = d;
    iorq_n_out = 1'b0;
    wr_n_out = !wr;
    rd_n_out = wr;
    @(negedge clk_in);
    q = bus_in;
    @(posedge clk_in);
    #1;
    {iorq_n_out, rd_n_out, wr_n_out} = 3'h7;
    drv_out = ~d;
  endtask
endmodule
`default_nettype wire

// File: system_glue_bank_latch_test.sv
// self-checking bench for the bank latch glue block
`timescale 1ns/100ps
`default_nettype none
module system_glue_bank_latch_test;
  logic sys_clk_in, nrst_in, addr_bit13_in, iorq_n_in, rd_n_in, wr_n_in, main_cpu_active_in;
  logic memory_enable_zero_in, memory_enable_one_in, sub_read_timing_in, clock_phase_in;
  logic bus_request_in, combined_read_n_out, combined_read_oe_n_out, system_off_flag_in;
  logic weak_battery_in, system_reset_n_in, return_data_enable_n_out, cmd_data_strobe_out;
  logic inverted_addr_bit13_out, bank3_chip_select_n_in, bank3_lower_sel_n_out, uart_clock_out;
  logic bank3_upper_sel_n_out, break_key_n_in, key_break_high_out, sub_clock_in;
  logic [7:0] addr_low_in, data_in, data_out, data_oe_n_out, secondary_return_bits_in, drv, q, e;
  logic [2:0] bank_address_outputs_out, slot_memory_select_n_in, slot_io_select_n_in;
  logic [2:0] slot_memory_select_n_out, slot_io_select_n_out;
  int         n_errors, checked, i;
  assign data_in = (data_oe_n_out & drv) | (~data_oe_n_out & data_out);
  system_glue_bank_latch system_glue_bank_latch_inst (.*);
  main_bus_model main_bus_model_inst (.clk_in(sys_clk_in), .bus_in(data_in),
    .addr_out(addr_low_in), .iorq_n_out(iorq_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
    .drv_out(drv));
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    main_bus_model_inst.cycle(a, d, 1'b1, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    sub_clock_in = 1'b0;
    forever #406.9 sub_clock_in = ~sub_clock_in;
  end
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial begin
    {n_errors, checked} = '0;
    {nrst_in, addr_bit13_in, main_cpu_active_in, memory_enable_zero_in, memory_enable_one_in,
     sub_read_timing_in, clock_phase_in, bus_request_in, system_off_flag_in} = '0;
    {weak_battery_in, system_reset_n_in, break_key_n_in, bank3_chip_select_n_in} = 4'h7;
    {slot_memory_select_n_in, slot_io_select_n_in} = 6'h15;
    secondary_return_bits_in = 8'h96;
    tick(10);
    nrst_in = 1'b1;
    chk("bank_rst", 8'h05, {5'h0, bank_address_outputs_out});
    for (i = 0; i < 8; i++) begin
      wr(8'h3d, 8'ha8 | 8'(i));
      chk("bank", 8'(i), {5'h0, bank_address_outputs_out});
    end
    wr(8'h3c, 8'h00);
    chk("bank_hold", 8'h07, {5'h0, bank_address_outputs_out});
    system_reset_n_in = 1'b0;
    wr(8'h3d, 8'h02);
    chk("bank_sys", 8'h05, {5'h0, bank_address_outputs_out});
    system_reset_n_in = 1'b1;
    bank3_chip_select_n_in = 1'b0;
    tick(2);
    chk("bank3_up", 8'h01, {6'h0, bank3_upper_sel_n_out, bank3_lower_sel_n_out});
    wr(8'h3d, 8'h03);
    chk("bank3_lo", 8'h02, {6'h0, bank3_upper_sel_n_out, bank3_lower_sel_n_out});
    main_bus_model_inst.cycle(8'h33, 8'h00, 1'b0, q);
    chk("read", 8'h96, q);
    chk("slots_on", 8'h15, {2'h0, slot_memory_select_n_out, slot_io_select_n_out});
    weak_battery_in = 1'b1;
    tick(1);
    chk("slots_weak", 8'h3f, {2'h0, slot_memory_select_n_out, slot_io_select_n_out});
    {weak_battery_in, system_off_flag_in} = 2'h1;
    tick(2);
    main_bus_model_inst.cycle(8'h33, 8'h00, 1'b0, q);
    chk("read_off", 8'h90, q);
    tick(1);
    chk("oe_off", 8'hf8, data_oe_n_out);
    chk("slots_off", 8'h3f, {2'h0, slot_memory_select_n_out, slot_io_select_n_out});
    chk("uart_off", 8'h00, {7'h0, uart_clock_out});
    {break_key_n_in, addr_bit13_in} = 2'h1;
    tick(2);
    chk("key_a13", 8'h02, {6'h0, key_break_high_out, inverted_addr_bit13_out});
    for (i = 0; i < 64; i++) begin
      {main_cpu_active_in, memory_enable_zero_in, memory_enable_one_in, sub_read_timing_in,
       clock_phase_in, bus_request_in} = 6'(i);
      e = {6'h0, i[5], !((i[4] | i[3]) & !i[2] & i[1] & !i[0])};
      tick(1);
      chk("rd", e, {6'h0, combined_read_oe_n_out, combined_read_n_out});
    end
    stop_test();
  end
endmodule
bind system_glue_bank_latch system_glue_bank_latch_properties
  system_glue_bank_latch_properties_inst (.*);
`default_nettype wire
